// [common/pdsr_pkg.sv]
// constants and types shared by the debug and scratch register slice
package pdsr_pkg;
    localparam int unsigned PDSR_ADDR_W = 6;
    localparam int unsigned PDSR_DATA_W = 8;
    localparam logic [5:0] PDSR_OFS_LINE_DEBUG = 6'h15;
    localparam logic [5:0] PDSR_OFS_SCRATCH = 6'h16;
    localparam logic [5:0] PDSR_OFS_SCRATCH_SET = 6'h17;
    localparam logic [5:0] PDSR_OFS_SCRATCH_CLR = 6'h18;
    localparam logic [7:0] PDSR_SCRATCH_RST = 8'h00;
    localparam logic [7:0] PDSR_RDATA_RST = 8'h00;
    localparam logic [7:0] PDSR_UNMAPPED_RD = 8'h00;
    localparam int unsigned PDSR_LVL_LSB = 0;
    localparam int unsigned PDSR_LVL_W = 2;
    localparam logic [1:0] PDSR_LVL_SE0_SQUELCH = 2'h0;
    localparam logic [1:0] PDSR_LVL_ONE = 2'h1;
    localparam logic [1:0] PDSR_LVL_TWO = 2'h2;
    localparam logic [1:0] PDSR_LVL_SE1_INVALID = 2'h3;

    // receiver operating mode, one-hot
    typedef enum logic [3:0] {
        PDSR_MODE_LS = 4'h1,
        PDSR_MODE_FS = 4'h2,
        PDSR_MODE_HS = 4'h4,
        PDSR_MODE_CHIRP = 4'h8
    } pdsr_mode_t;

    // scratch operation, one-hot plus idle
    typedef enum logic [2:0] {
        PDSR_OP_NONE = 3'h0,
        PDSR_OP_WRITE = 3'h1,
        PDSR_OP_SET = 3'h2,
        PDSR_OP_CLEAR = 3'h4
    } pdsr_op_t;
endpackage

// [common/pdsr_scratch_if.sv]
// carrier between the register decoder and the scratch byte store
`timescale 1ns/1ps
interface pdsr_scratch_if;
    import pdsr_pkg::*;
    pdsr_op_t op;
    logic [7:0] wdata;
    logic [7:0] value;
    modport decoder (output op, output wdata, input value);
    modport store (input op, input wdata, output value);
endinterface

// [rtl/pdsr_scratch_store.sv]
// eight-bit scratch byte with write, bit set and bit clear operations
`timescale 1ns/1ps
module pdsr_scratch_store (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // access from the decoder
    pdsr_scratch_if.store sif
);
    import pdsr_pkg::*;

    typedef struct packed {
        logic [7:0] byte_q;
    } pdsr_store_state_t;

    pdsr_store_state_t st_q;
    pdsr_store_state_t st_d;

    always_comb begin
        st_d = st_q;
        case (sif.op)
            PDSR_OP_WRITE: st_d.byte_q = sif.wdata;
            PDSR_OP_SET: st_d.byte_q = st_q.byte_q | sif.wdata;
            PDSR_OP_CLEAR: st_d.byte_q = st_q.byte_q & ~sif.wdata;
            default: st_d.byte_q = st_q.byte_q;
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_q.byte_q <= PDSR_SCRATCH_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign sif.value = st_q.byte_q;

    a_set_keeps_ones: assert property (@(posedge clock) disable iff (sys_rst)
        sif.op == PDSR_OP_SET |=> (sif.value == ($past(sif.value) | $past(sif.wdata))))
        else $error("set alias changed a bit written as zero");
    a_idle_holds: assert property (@(posedge clock) disable iff (sys_rst)
        sif.op == PDSR_OP_NONE |=> $stable(sif.value))
        else $error("scratch byte changed without a write");
    a_write_stores: assert property (@(posedge clock) disable iff (sys_rst)
        sif.op == PDSR_OP_WRITE |=> sif.value == $past(sif.wdata))
        else $error("scratch write did not store the byte");
endmodule

// [rtl/pdsr_regs.sv]
// debug line-state and scratch register slice behind the register access port
// What this block does
// - read-only debug register at 0x15, upper bits zero
// - low bits show live receiver outputs
// - bit0 positive line, bit1 negative line
// - code 0 is SE0 or squelch
// - code 1 is K/J/not-squelch/chirp high
// - code 2 is J/K/invalid/chirp low
// - code 3 is SE1 or invalid
// - scratch byte at 0x16, resets to zero
// - scratch byte affects nothing else
// - scratch read, write, set and clear
// - 0x17 aliases the scratch byte
// - set alias ORs written ones in
// - set alias reads back scratch byte
`timescale 1ns/1ps
module pdsr_regs (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // register access from the link
    input wire logic [pdsr_pkg::PDSR_ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [pdsr_pkg::PDSR_DATA_W-1:0] reg_wdata,
    output logic [pdsr_pkg::PDSR_DATA_W-1:0] reg_rdata,
    output logic reg_rvalid,
    // receiver front end
    input wire pdsr_pkg::pdsr_mode_t rx_mode,
    input wire logic positive_data_line,
    input wire logic negative_data_line,
    input wire logic squelch,
    input wire logic high_speed_diff_receiver_out,
    // registered line-state copy, one clock behind the receivers
    output logic [pdsr_pkg::PDSR_LVL_W-1:0] single_ended_rx_level
);
    import pdsr_pkg::*;

    typedef struct packed {
        logic [7:0] rdata_q;
        logic rvalid_q;
        logic [1:0] level_q;
    } pdsr_state_t;

    pdsr_state_t st_q;
    pdsr_state_t st_d;
    logic [1:0] level_now;
    logic [7:0] rd_word;
    pdsr_op_t op_now;

    pdsr_scratch_if sif ();

    pdsr_scratch_store u_store (
        .clock(clock),
        .sys_rst(sys_rst),
        .sif(sif)
    );

    // line state from the receivers as they are this cycle
    always_comb begin
        level_now = PDSR_LVL_SE0_SQUELCH;
        case (rx_mode)
            PDSR_MODE_HS: level_now = squelch ? PDSR_LVL_SE0_SQUELCH : PDSR_LVL_ONE;
            PDSR_MODE_CHIRP: level_now = squelch ? PDSR_LVL_SE0_SQUELCH :
                (high_speed_diff_receiver_out ? PDSR_LVL_ONE : PDSR_LVL_TWO);
            default: level_now = {negative_data_line, positive_data_line};
        endcase
    end

    // address decode for reads and writes
    always_comb begin
        rd_word = PDSR_UNMAPPED_RD;
        op_now = PDSR_OP_NONE;
        if (reg_addr == PDSR_OFS_LINE_DEBUG) begin
            rd_word[PDSR_LVL_LSB +: PDSR_LVL_W] = level_now;
        end else if (reg_addr == PDSR_OFS_SCRATCH || reg_addr == PDSR_OFS_SCRATCH_SET
                || reg_addr == PDSR_OFS_SCRATCH_CLR) begin
            rd_word = sif.value;
        end
        if (reg_wr) begin
            if (reg_addr == PDSR_OFS_SCRATCH) begin
                op_now = PDSR_OP_WRITE;
            end else if (reg_addr == PDSR_OFS_SCRATCH_SET) begin
                op_now = PDSR_OP_SET;
            end else if (reg_addr == PDSR_OFS_SCRATCH_CLR) begin
                op_now = PDSR_OP_CLEAR;
            end
        end
    end

    assign sif.op = op_now;
    assign sif.wdata = reg_wdata;

    always_comb begin
        st_d = st_q;
        st_d.rvalid_q = reg_rd;
        if (reg_rd) begin
            st_d.rdata_q = rd_word;
        end
        st_d.level_q = level_now;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_q.rdata_q <= PDSR_RDATA_RST;
            st_q.rvalid_q <= 1'b0;
            st_q.level_q <= PDSR_LVL_SE0_SQUELCH;
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_rdata = st_q.rdata_q;
    assign reg_rvalid = st_q.rvalid_q;
    assign single_ended_rx_level = st_q.level_q;

    sequence s_debug_read;
        reg_rd && reg_addr == PDSR_OFS_LINE_DEBUG;
    endsequence

    // single-cycle accesses, the building blocks of the checks below
    sequence s_scratch_write;
        reg_wr && !reg_rd && reg_addr == PDSR_OFS_SCRATCH;
    endsequence

    sequence s_set_write;
        reg_wr && !reg_rd && reg_addr == PDSR_OFS_SCRATCH_SET;
    endsequence

    sequence s_clear_write;
        reg_wr && !reg_rd && reg_addr == PDSR_OFS_SCRATCH_CLR;
    endsequence

    sequence s_debug_write;
        reg_wr && !reg_rd && reg_addr == PDSR_OFS_LINE_DEBUG;
    endsequence

    sequence s_scratch_read;
        reg_rd && !reg_wr && reg_addr == PDSR_OFS_SCRATCH;
    endsequence

    // read-back checks only engage with one quiet cycle after the write
    sequence s_set_then_read;
        s_set_write ##1 !reg_wr ##1 s_scratch_read;
    endsequence

    sequence s_write_then_read;
        s_scratch_write ##1 !reg_wr ##1 s_scratch_read;
    endsequence

    sequence s_clear_then_read;
        s_clear_write ##1 !reg_wr ##1 s_scratch_read;
    endsequence

    sequence s_debug_write_then_read;
        s_debug_write ##1 !reg_wr ##1 s_debug_read;
    endsequence

    a_debug_upper_zero: assert property (@(posedge clock) disable iff (sys_rst)
        s_debug_read |=> reg_rvalid && reg_rdata[7:2] == 6'h00)
        else $error("debug read returned nonzero reserved bits");
    a_debug_live: assert property (@(posedge clock) disable iff (sys_rst)
        s_debug_read |=> reg_rdata[1:0] == $past(level_now))
        else $error("debug read not the live line state");
    a_fs_line_order: assert property (@(posedge clock) disable iff (sys_rst)
        (s_debug_read and (rx_mode == PDSR_MODE_FS))
        |=> reg_rdata[1:0] == {$past(negative_data_line), $past(positive_data_line)})
        else $error("line bits in wrong order");
    a_squelch_zero: assert property (@(posedge clock) disable iff (sys_rst)
        (rx_mode == PDSR_MODE_HS || rx_mode == PDSR_MODE_CHIRP) && squelch
        |=> single_ended_rx_level == PDSR_LVL_SE0_SQUELCH)
        else $error("squelch not reported as zero");
    a_chirp_code: assert property (@(posedge clock) disable iff (sys_rst)
        rx_mode == PDSR_MODE_CHIRP && !squelch
        |=> single_ended_rx_level == ($past(high_speed_diff_receiver_out) ? PDSR_LVL_ONE : PDSR_LVL_TWO))
        else $error("chirp level code wrong");
    a_set_alias_read: assert property (@(posedge clock) disable iff (sys_rst)
        reg_rd && reg_addr == PDSR_OFS_SCRATCH_SET |=> reg_rdata == $past(sif.value))
        else $error("set alias read differs from scratch byte");
    a_set_then_read: assert property (@(posedge clock) disable iff (sys_rst)
        s_set_then_read |=> (reg_rdata & $past(reg_wdata, 3)) == $past(reg_wdata, 3))
        else $error("bit set through alias not visible in scratch");
    a_debug_write_inert: assert property (@(posedge clock) disable iff (sys_rst)
        reg_wr && reg_addr == PDSR_OFS_LINE_DEBUG |-> op_now == PDSR_OP_NONE)
        else $error("debug write reached the scratch byte");

    // read-back, read-port timing and line-state code checks
    a_write_then_read: assert property (@(posedge clock) disable iff (sys_rst)
        s_write_then_read |=> reg_rdata == $past(reg_wdata, 3))
        else $error("scratch byte did not keep the written value");
    a_clear_then_read: assert property (@(posedge clock) disable iff (sys_rst)
        s_clear_then_read |=> (reg_rdata & $past(reg_wdata, 3)) == 8'h00)
        else $error("bit clear through alias left a one set");
    a_debug_stays_live: assert property (@(posedge clock) disable iff (sys_rst)
        s_debug_write_then_read |=> reg_rdata == {6'h00, $past(level_now)})
        else $error("debug read after a debug write not live");
    a_rvalid_pulse: assert property (@(posedge clock) disable iff (sys_rst)
        reg_rd |=> reg_rvalid)
        else $error("read not answered in the next cycle");
    a_no_stray_rvalid: assert property (@(posedge clock) disable iff (sys_rst)
        !reg_rd |=> !reg_rvalid)
        else $error("read valid without a read request");
    a_rdata_holds: assert property (@(posedge clock) disable iff (sys_rst)
        !reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");
    a_se1_code: assert property (@(posedge clock) disable iff (sys_rst)
        (rx_mode == PDSR_MODE_LS || rx_mode == PDSR_MODE_FS) && positive_data_line && negative_data_line
        |=> single_ended_rx_level == PDSR_LVL_SE1_INVALID)
        else $error("both lines high not reported as SE1");
    a_ls_line_order: assert property (@(posedge clock) disable iff (sys_rst)
        rx_mode == PDSR_MODE_LS && negative_data_line && !positive_data_line
        |=> single_ended_rx_level == PDSR_LVL_TWO)
        else $error("low-speed J state not reported as code two");
    a_hs_not_squelch: assert property (@(posedge clock) disable iff (sys_rst)
        rx_mode == PDSR_MODE_HS && !squelch |=> single_ended_rx_level == PDSR_LVL_ONE)
        else $error("high-speed activity not reported as code one");
endmodule

// [bench/pdsr_link_model.sv]
// link controller model issuing single register reads and writes
`timescale 1ns/1ps
module pdsr_link_model (
    // clock
    input wire logic clock,
    // register requests
    output logic [5:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_wdata
);
    import pdsr_pkg::*;
    initial begin
        reg_addr = 6'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end
    // one request held across its sampling edge
    task automatic req(input logic wr, input logic [5:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = wr;
        reg_rd = !wr;
        @(negedge clock);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        // released address and data lines are driven to their inverse, not left at the last value
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
endmodule

// [bench/phy_debug_scratch_regs_tb.sv]
// self-checking bench for the debug and scratch register slice
`timescale 1ns/1ps
module phy_debug_scratch_regs_tb;
    import pdsr_pkg::*;
    logic clock, sys_rst, reg_wr, reg_rd, reg_rvalid, pos, neg, sq, hd;
    logic [5:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, sc, w, e;
    logic [1:0] lvl_q;
    logic [5:0] wa[4] = '{PDSR_OFS_SCRATCH, PDSR_OFS_SCRATCH_SET, PDSR_OFS_SCRATCH_CLR, PDSR_OFS_LINE_DEBUG};
    pdsr_mode_t rx_mode;
    logic [7:0] exp_q[$];
    int mismatches = 0;
    int n_compared = 0;
    pdsr_link_model link (.clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata));
    pdsr_regs dut (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .rx_mode(rx_mode),
        .positive_data_line(pos), .negative_data_line(neg), .squelch(sq),
        .high_speed_diff_receiver_out(hd), .single_ended_rx_level(lvl_q));
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] x);
        exp_q.push_back(x);
        link.req(1'b0, a, 8'h00);
    endtask
    function automatic logic [1:0] code(input logic [1:0] m, input logic p, n, s, h);
        if (m == 2'd2) return s ? 2'h0 : 2'h1;
        if (m == 2'd3) return s ? 2'h0 : (h ? 2'h1 : 2'h2);
        return {n, p};
    endfunction
    // read results are taken oldest first
    always @(negedge clock) begin
        if (reg_rvalid === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("unrequested read valid", 8'h01, 8'h00);
            end else begin
                check("read data", reg_rdata, exp_q.pop_front());
            end
        end
    end
    initial begin
        repeat (20000) @(posedge clock);
        check("watchdog", 8'h01, 8'h00);
        final_report();
    end
    initial begin
        void'($urandom(32'hf067c7ee));
        sys_rst = 1'b1;
        rx_mode = PDSR_MODE_FS;
        {pos, neg, sq, hd} = 4'h0;
        repeat (16) @(posedge clock);
        @(negedge clock);
        sys_rst = 1'b0;
        rd(PDSR_OFS_SCRATCH, PDSR_SCRATCH_RST);
        rd(PDSR_OFS_SCRATCH_SET, PDSR_SCRATCH_RST);
        sc = PDSR_SCRATCH_RST;
        // each access kind, then read through both offsets
        for (int i = 0; i < 16; i++) begin
            w = 8'($urandom());
            link.req(1'b1, wa[i % 4], w);
            case (i % 4)
                0: sc = w;
                1: sc = sc | w;
                2: sc = sc & ~w;
                default: sc = sc;
            endcase
            rd(PDSR_OFS_SCRATCH, sc);
            rd(PDSR_OFS_SCRATCH_SET, sc);
        end
        // live line state in every mode, writes to it ignored
        for (int i = 0; i < 64; i++) begin
            @(negedge clock);
            rx_mode = pdsr_mode_t'(4'h1 << i[5:4]);
            {hd, sq, neg, pos} = i[3:0];
            e = {6'h00, code(i[5:4], pos, neg, sq, hd)};
            if (i % 8 == 3) link.req(1'b1, PDSR_OFS_LINE_DEBUG, 8'($urandom()));
            rd(PDSR_OFS_LINE_DEBUG, e);
            check("line level copy", {6'h00, lvl_q}, e);
        end
        rd(PDSR_OFS_SCRATCH, sc);
        rd(6'h3f, PDSR_UNMAPPED_RD);
        @(negedge clock);
        sys_rst = 1'b1;
        repeat (2) @(negedge clock);
        sys_rst = 1'b0;
        rd(PDSR_OFS_SCRATCH, PDSR_SCRATCH_RST);
        for (int k = 0; k < 8 && exp_q.size() != 0; k++) @(posedge clock);
        check("pending reads", 8'(exp_q.size()), 8'h00);
        final_report();
    end
endmodule
